// [core/sic_pkg.sv]
/*
   Shared constants of the six-source interrupt controller: register
   addresses, field positions, reset values, machine-cycle tick positions,
   source indices and vector addresses.
   Assumes an 8-bit special function register bus and a CPU core that
   takes one vector at a time and reports the end of each service routine.
*/
package sic_pkg;

   // Register addresses on the special function register bus.
   localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hA8;
   localparam logic [7:0] PRIO_HIGH_ADDR = 8'hB7;
   localparam logic [7:0] PRIO_LOW_ADDR = 8'hB8;

   // Reset values.
   localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
   localparam logic [7:0] PRIO_HIGH_RESET = 8'h00;
   localparam logic [7:0] PRIO_LOW_RESET = 8'h00;

   // Field positions; the source index equals its bit in all three registers.
   localparam int GLOBAL_ENABLE_BIT = 7;
   localparam int RESERVED_BIT = 6;
   localparam int SRC_EXT0 = 0;
   localparam int SRC_TIMER0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_TIMER1 = 3;
   localparam int SRC_SERIAL = 4;
   localparam int SRC_TIMER2 = 5;
   localparam int SOURCE_COUNT = 6;

   // Writable bits: enable register lacks bit 6, priority registers lack 7 and 6.
   localparam logic [7:0] IRQ_ENABLE_MASK = 8'hBF;
   localparam logic [7:0] PRIO_MASK = 8'h3F;

   // Machine cycle: six states of two phases, one tick per clock.
   localparam logic [3:0] CYCLE_LAST_TICK = 4'hB;
   localparam logic [3:0] TICK_STATE2_PHASE2 = 4'h3;
   localparam logic [3:0] TICK_STATE5_PHASE2 = 4'h9;
   localparam logic [3:0] TICK_POLL = 4'hB;

   // Vector addresses.
   localparam logic [15:0] VECTOR_RESET = 16'h0000;
   localparam logic [15:0] VECTOR_EXT0 = 16'h0003;
   localparam logic [15:0] VECTOR_TIMER0 = 16'h000B;
   localparam logic [15:0] VECTOR_EXT1 = 16'h0013;
   localparam logic [15:0] VECTOR_TIMER1 = 16'h001B;
   localparam logic [15:0] VECTOR_SERIAL = 16'h0023;
   localparam logic [15:0] VECTOR_TIMER2 = 16'h002B;

   typedef enum logic [0:0] {
      SIC_IDLE = 1'b0,
      SIC_OFFER = 1'b1
   } sic_state_type;

endpackage

// [core/sic_sync.sv]
/*
   Two-flip-flop synchroniser for one level from outside the clock domain.
   Assumes the input may change at any time relative to clock.
*/
`timescale 1ns/1ns
module sic_sync #(
   parameter logic RESET_LEVEL = 1'b1
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic async_in,
   output logic sync_out
);

   logic first_stage;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         first_stage <= RESET_LEVEL;
         sync_out <= RESET_LEVEL;
      end
      else
      begin
         first_stage <= async_in;
         sync_out <= first_stage;
      end
   end

endmodule

// [core/sic_controller.sv]
/*
   Six-source interrupt controller with per-source and global enables, four
   priority levels and vectoring of the CPU core.
   Assumes peripheral flags arrive on this clock, external pins arrive
   asynchronously, and the CPU pulses irq_ack when it takes the offered
   vector and irq_return when a service routine ends.
*/
`timescale 1ns/1ns
// What this block does
// [RQ1] Six request sources, each with its own vector.
// [RQ2] Each source has its own enable; a global bit gates all.
// [RQ3] Enable one allows a source, zero blocks it.
// [RQ4] Global enable at bit 7 zero means nothing is acknowledged; an offer already raised can still be taken until the next poll.
// [RQ5] Enables: timer2 5, serial 4, timer1 3, ext1 2, timer0 1, ext0 0.
// [RQ6] Software never writes one to enable bit 6, which is unimplemented.
// [RQ7] Timer2 request ORs its two flags; vectoring clears neither.
// [RQ8] Timer2 service routine finds and clears the causing flag itself.
// [RQ9] Serial request ORs receive, transmit and SPI flag, SPI only if enabled.
// [RQ10] Vectoring clears no serial flag; software finds UART or SPI.
// [RQ11] Timer0 and timer1 flags set at state5_phase2 are polled next cycle.
// [RQ12] Timer2 flag set at state2_phase2 is polled in the same cycle.
// [RQ13] Low priority register holds one bit per source; bits 7 and 6 unused.
// [RQ14] High priority register uses the same layout; bits 7 and 6 unused.
// [RQ15] SPI completion requests only when SPI and serial enables are both one.
// [RQ16] Vectors 0003H, 000BH, 0013H, 001BH, 0023H, timer2 at 002BH.
// [RQ17] Two priority bits give four levels; higher preempts, ties by poll order.
module sic_controller
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_write,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic ext0_pin,
   input wire logic ext1_pin,
   input wire logic timer0_overflow_flag,
   input wire logic timer1_overflow_flag,
   input wire logic timer2_overflow_flag,
   input wire logic timer2_ext_flag,
   input wire logic rx_done_flag,
   input wire logic tx_done_flag,
   input wire logic spi_done_flag,
   input wire logic spi_irq_enable,
   input wire logic irq_ack,
   input wire logic irq_return,
   output logic irq_request,
   output logic [15:0] irq_vector,
   output logic [1:0] irq_level
);
   import sic_pkg::*;

   logic [7:0] irq_enable_reg;
   logic [7:0] prio_high_reg;
   logic [7:0] prio_low_reg;
   logic [3:0] phase_count;
   logic ext0_sync;
   logic ext1_sync;
   logic [SOURCE_COUNT-1:0] polled;
   logic [SOURCE_COUNT-1:0] gated;
   logic [3:0] in_service;
   logic [3:0] next_in_service;
   logic [1:0] cur_level;
   logic win_found;
   logic [2:0] win_idx;
   logic [1:0] win_level;
   logic win_allowed;
   logic [2:0] irq_src;
   logic [15:0] win_vector;
   sic_state_type state;
   logic tick_poll;
   logic tick_state5;
   logic tick_after_state2;

   sic_sync #(.RESET_LEVEL(1'b1)) sync_ext0 (
      .clock(clock),
      .resetn(resetn),
      .async_in(ext0_pin),
      .sync_out(ext0_sync)
   );

   sic_sync #(.RESET_LEVEL(1'b1)) sync_ext1 (
      .clock(clock),
      .resetn(resetn),
      .async_in(ext1_pin),
      .sync_out(ext1_sync)
   );

   // Machine-cycle divider: one tick per clock, twelve ticks per cycle.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         phase_count <= 4'h0;
      else if (phase_count == CYCLE_LAST_TICK)
         phase_count <= 4'h0;
      else
         phase_count <= phase_count + 4'h1;
   end

   assign tick_poll = (phase_count == TICK_POLL);
   assign tick_state5 = (phase_count == TICK_STATE5_PHASE2);
   assign tick_after_state2 = (phase_count == TICK_STATE2_PHASE2 + 4'h1);

   // Register writes; unimplemented bits are never stored.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_enable_reg <= IRQ_ENABLE_RESET;
         prio_high_reg <= PRIO_HIGH_RESET;
         prio_low_reg <= PRIO_LOW_RESET;
      end
      else if (sfr_write)
      begin
         if (sfr_addr == IRQ_ENABLE_ADDR)
            irq_enable_reg <= sfr_wdata & IRQ_ENABLE_MASK; // RQ5 RQ6
         if (sfr_addr == PRIO_HIGH_ADDR)
            prio_high_reg <= sfr_wdata & PRIO_MASK; // RQ14
         if (sfr_addr == PRIO_LOW_ADDR)
            prio_low_reg <= sfr_wdata & PRIO_MASK; // RQ13
      end
   end

   // Read data, one clock after the address; other addresses read zero.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         sfr_rdata <= 8'h00;
      else
      begin
         case (sfr_addr)
            IRQ_ENABLE_ADDR: sfr_rdata <= irq_enable_reg;
            PRIO_HIGH_ADDR: sfr_rdata <= prio_high_reg;
            PRIO_LOW_ADDR: sfr_rdata <= prio_low_reg;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // Request latches. A timer0 or timer1 flag that rises at state5_phase2 is
   // caught at the next cycle's state5_phase2, so it is polled a cycle later.
   // The timer2 flag is caught just after state2_phase2 and polled in the
   // same cycle. Flags are only sampled; none is ever cleared here.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         polled <= '0;
      else
      begin
         polled[SRC_EXT0] <= !ext0_sync;
         polled[SRC_EXT1] <= !ext1_sync;
         if (tick_state5)
         begin
            polled[SRC_TIMER0] <= timer0_overflow_flag; // RQ11
            polled[SRC_TIMER1] <= timer1_overflow_flag; // RQ11
            polled[SRC_SERIAL] <= rx_done_flag | tx_done_flag | (spi_done_flag & spi_irq_enable); // RQ9 RQ10 RQ15
         end
         if (tick_after_state2)
            polled[SRC_TIMER2] <= timer2_overflow_flag | timer2_ext_flag; // RQ7 RQ12
      end
   end

   assign gated = polled & irq_enable_reg[SOURCE_COUNT-1:0]
                  & {SOURCE_COUNT{irq_enable_reg[GLOBAL_ENABLE_BIT]}}; // RQ2 RQ3 RQ4 RQ15

   // Highest level wins; within a level the lowest index is polled first.
   always_comb
   begin
      win_found = 1'b0;
      win_idx = 3'h0;
      win_level = 2'h0;
      for (int l = 3; l >= 0; l--)
      begin
         for (int i = 0; i < SOURCE_COUNT; i++)
         begin
            if (!win_found && gated[i] && ({prio_high_reg[i], prio_low_reg[i]} == 2'(l))) // RQ17
            begin
               win_found = 1'b1;
               win_idx = 3'(i);
               win_level = 2'(l);
            end
         end
      end
   end

   always_comb
   begin
      cur_level = 2'h0;
      for (int l = 0; l < 4; l++)
      begin
         if (in_service[l])
            cur_level = 2'(l);
      end
   end

   assign win_allowed = win_found && ((in_service == 4'h0) || (win_level > cur_level)); // RQ17

   always_comb
   begin
      case (win_idx)
         3'h0: win_vector = VECTOR_EXT0; // RQ1 RQ16
         3'h1: win_vector = VECTOR_TIMER0;
         3'h2: win_vector = VECTOR_EXT1;
         3'h3: win_vector = VECTOR_TIMER1;
         3'h4: win_vector = VECTOR_SERIAL;
         3'h5: win_vector = VECTOR_TIMER2;
         default: win_vector = VECTOR_RESET;
      endcase
   end

   // Offer to the CPU: re-evaluated at each poll until the CPU takes it.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= SIC_IDLE;
         irq_request <= 1'b0;
         irq_vector <= VECTOR_RESET;
         irq_level <= 2'h0;
         irq_src <= 3'h0;
      end
      else
      begin
         case (state)
            SIC_IDLE:
            begin
               if (tick_poll && win_allowed)
               begin
                  state <= SIC_OFFER;
                  irq_request <= 1'b1;
                  irq_vector <= win_vector;
                  irq_level <= win_level;
                  irq_src <= win_idx;
               end
            end
            SIC_OFFER:
            begin
               if (irq_ack)
               begin
                  state <= SIC_IDLE;
                  irq_request <= 1'b0;
               end
               else if (tick_poll)
               begin
                  if (win_allowed)
                  begin
                     irq_vector <= win_vector;
                     irq_level <= win_level;
                     irq_src <= win_idx;
                  end
                  else
                  begin
                     state <= SIC_IDLE;
                     irq_request <= 1'b0; // RQ4
                  end
               end
            end
            default:
            begin
               state <= SIC_IDLE;
               irq_request <= 1'b0;
            end
         endcase
      end
   end

   // One in-service bit per level; a return ends the highest active level.
   // A return and a take in one cycle: the return is applied first.
   always_comb
   begin
      next_in_service = in_service;
      if (irq_return && (in_service != 4'h0))
         next_in_service[cur_level] = 1'b0;
      if (irq_request && irq_ack)
         next_in_service[irq_level] = 1'b1; // RQ17
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         in_service <= 4'h0;
      else
         in_service <= next_in_service;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence offer_taken_seq;
      irq_request && irq_ack;
   endsequence

   sequence offer_new_seq;
      $rose(irq_request);
   endsequence

   a_global_gate: assert property (offer_new_seq |-> $past(irq_enable_reg[GLOBAL_ENABLE_BIT])) // RQ4
      else $error("request offered while global enable was off");
   a_source_enable: assert property (tick_poll && win_found
      |-> irq_enable_reg[win_idx] && irq_enable_reg[GLOBAL_ENABLE_BIT]) // RQ2 RQ3
      else $error("offered source is not enabled");
   a_poll_moment: assert property (offer_new_seq |-> $past(phase_count) == TICK_POLL) // RQ11 RQ12
      else $error("request offered outside the poll tick");
   a_vector_map: assert property (irq_request && irq_src == 3'(SRC_TIMER2) |-> irq_vector == VECTOR_TIMER2) // RQ16
      else $error("timer2 vector wrong");
   a_vector_ext0: assert property (irq_request && irq_src == 3'(SRC_EXT0) |-> irq_vector == VECTOR_EXT0) // RQ1 RQ16
      else $error("external 0 vector wrong");
   a_preempt_level: assert property (offer_new_seq |-> $past(in_service) == 4'h0
      || irq_level > $past(cur_level)) // RQ17
      else $error("offer does not exceed the level in service");
   a_ack_service: assert property (offer_taken_seq |=> !irq_request && in_service[$past(irq_level)]) // RQ17
      else $error("taken offer not recorded as in service");
   a_enable_write: assert property (sfr_write && sfr_addr == IRQ_ENABLE_ADDR
      |=> irq_enable_reg == ($past(sfr_wdata) & IRQ_ENABLE_MASK)) // RQ5 RQ6
      else $error("enable register write wrong");
   a_prio_unused: assert property (sfr_addr == PRIO_LOW_ADDR || sfr_addr == PRIO_HIGH_ADDR
      |=> sfr_rdata[7:6] == 2'h0) // RQ13 RQ14
      else $error("unused priority bits read nonzero");
   a_timer2_or: assert property (tick_after_state2
      |=> polled[SRC_TIMER2] == $past(timer2_overflow_flag | timer2_ext_flag)) // RQ7 RQ12
      else $error("timer2 request is not the OR of its flags");
   a_serial_or: assert property (tick_state5 |=> polled[SRC_SERIAL]
      == $past(rx_done_flag | tx_done_flag | (spi_done_flag & spi_irq_enable))) // RQ9 RQ15
      else $error("serial request wrong");
   a_timer0_late: assert property (!tick_state5 && !$rose(tick_state5) |=> $stable(polled[SRC_TIMER0])) // RQ11
      else $error("timer0 request sampled outside state5_phase2");

endmodule

// [tb/sic_cpu_model.sv]
/*
   Model of the CPU core: takes each offered vector and ends the service
   routine a set number of cycles later; a hold of zero never ends it.
   Assumes it drives on the falling edge and the controller samples on the rising edge.
*/
`timescale 1ns/1ns
module sic_cpu_model
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic irq_request,
   input wire logic [15:0] irq_vector,
   input wire logic [1:0] irq_level,
   input wire logic ack_on,
   input wire logic [7:0] hold_cycles,
   output logic irq_ack,
   output logic irq_return,
   output logic [15:0] taken_vector,
   output logic [1:0] taken_level,
   output logic [7:0] taken_count
);
   logic [7:0] serve;

   always_ff @(negedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_ack <= 1'b0;
         irq_return <= 1'b0;
         serve <= 8'h00;
      end
      else
      begin
         irq_ack <= ack_on && irq_request && !irq_ack;
         irq_return <= (serve == 8'h01);
         if (irq_ack)
            serve <= hold_cycles;
         else if (serve != 8'h00)
            serve <= serve - 8'h01;
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         taken_count <= 8'h00;
         taken_vector <= 16'h0000;
         taken_level <= 2'h0;
      end
      else if (irq_ack && irq_request)
      begin
         taken_vector <= irq_vector;
         taken_level <= irq_level;
         taken_count <= taken_count + 8'h01;
      end
   end
endmodule

// [tb/six_source_interrupt_controller_test.sv]
/*
   Self-checking testbench of the interrupt controller with a CPU model.
   Assumes the controller's hand-over timing: registered reads, poll once per 12-clock machine cycle.
*/
`timescale 1ns/1ns
module six_source_interrupt_controller_test;
   import sic_pkg::*;
   logic clock, resetn, sfr_write, irq_ack, irq_return, irq_request, ack_on;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, hold_cycles, taken_count;
   logic ext0_pin, ext1_pin, timer0_overflow_flag, timer1_overflow_flag, timer2_overflow_flag;
   logic timer2_ext_flag, rx_done_flag, tx_done_flag, spi_done_flag, spi_irq_enable;
   logic [15:0] irq_vector, taken_vector;
   logic [1:0] irq_level, taken_level;
   logic [15:0] vec [6] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B};
   int fails = 0;
   int samples_checked = 0;

   sic_controller uut (.clock(clock), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext0_pin(ext0_pin), .ext1_pin(ext1_pin),
      .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag),
      .timer2_overflow_flag(timer2_overflow_flag), .timer2_ext_flag(timer2_ext_flag),
      .rx_done_flag(rx_done_flag), .tx_done_flag(tx_done_flag), .spi_done_flag(spi_done_flag),
      .spi_irq_enable(spi_irq_enable), .irq_ack(irq_ack), .irq_return(irq_return),
      .irq_request(irq_request), .irq_vector(irq_vector), .irq_level(irq_level));
   sic_cpu_model cpu (.clock(clock), .resetn(resetn), .irq_request(irq_request), .irq_vector(irq_vector),
      .irq_level(irq_level), .ack_on(ack_on), .hold_cycles(hold_cycles), .irq_ack(irq_ack),
      .irq_return(irq_return), .taken_vector(taken_vector), .taken_level(taken_level),
      .taken_count(taken_count));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock);
      sfr_addr = addr;
      sfr_wdata = data;
      sfr_write = 1'b1;
      @(negedge clock);
      sfr_write = 1'b0;
   endtask

   task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp);
      @(negedge clock);
      sfr_addr = addr;
      @(negedge clock);
      check8("register", exp, sfr_rdata);
   endtask

   // Drives a source to its asserted (v=1) or idle level; external pins are active low.
   task automatic set_src(input int i, input logic v);
      case (i)
         0: ext0_pin = !v;
         1: timer0_overflow_flag = v;
         2: ext1_pin = !v;
         3: timer1_overflow_flag = v;
         4: rx_done_flag = v;
         default: timer2_overflow_flag = v;
      endcase
   endtask

   task automatic expect_take(input logic [15:0] exp_vec, input logic [1:0] exp_lvl);
      logic [7:0] c0;
      int n;
      c0 = taken_count;
      n = 0;
      while (taken_count === c0 && n < 60)
      begin
         @(negedge clock);
         n++;
      end
      check8("taken", c0 + 8'h01, taken_count);
      check16("vector", exp_vec, taken_vector);
      check8("level", {6'h00, exp_lvl}, {6'h00, taken_level});
   endtask

   task automatic expect_none();
      logic [7:0] c0;
      c0 = taken_count;
      repeat (40) @(negedge clock);
      check8("taken", c0, taken_count);
   endtask

   task automatic end_test(input string name);
      $display("test %s finished: %0d checks, %0d failures", name, samples_checked, fails);
   endtask

   task automatic complete_run();
      $display("checks %0d failures %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      #100000;
      fails++;
      complete_run();
   end

   initial
   begin
      {resetn, sfr_write, sfr_addr, sfr_wdata, spi_irq_enable} = '0;
      {timer0_overflow_flag, timer1_overflow_flag, timer2_overflow_flag, timer2_ext_flag} = '0;
      {rx_done_flag, tx_done_flag, spi_done_flag} = '0;
      {ext0_pin, ext1_pin, ack_on} = 3'b111;
      hold_cycles = 8'h03;
      repeat (10) @(negedge clock);
      resetn = 1'b1;
      read_reg(IRQ_ENABLE_ADDR, 8'h00);
      read_reg(PRIO_HIGH_ADDR, 8'h00);
      read_reg(PRIO_LOW_ADDR, 8'h00);
      write_reg(IRQ_ENABLE_ADDR, 8'hBF);
      write_reg(PRIO_HIGH_ADDR, 8'hFF);
      write_reg(PRIO_LOW_ADDR, 8'hFF);
      read_reg(IRQ_ENABLE_ADDR, 8'hBF);
      read_reg(PRIO_HIGH_ADDR, 8'h3F);
      read_reg(PRIO_LOW_ADDR, 8'h3F);
      read_reg(8'h55, 8'h00);
      write_reg(PRIO_HIGH_ADDR, 8'h00);
      write_reg(PRIO_LOW_ADDR, 8'h00);
      end_test("registers");
      for (int i = 0; i < 6; i++)
      begin
         write_reg(IRQ_ENABLE_ADDR, 8'h80 | (8'h01 << i));
         set_src(i, 1'b1);
         expect_take(vec[i], 2'b00);
         set_src(i, 1'b0);
         repeat (6) @(negedge clock);
      end
      write_reg(IRQ_ENABLE_ADDR, 8'hA0);
      timer2_ext_flag = 1'b1;
      expect_take(16'h002B, 2'b00);
      expect_take(16'h002B, 2'b00);
      timer2_ext_flag = 1'b0;
      write_reg(IRQ_ENABLE_ADDR, 8'h90);
      tx_done_flag = 1'b1;
      expect_take(16'h0023, 2'b00);
      tx_done_flag = 1'b0;
      spi_done_flag = 1'b1;
      expect_none();
      spi_irq_enable = 1'b1;
      expect_take(16'h0023, 2'b00);
      spi_done_flag = 1'b0;
      end_test("vectors");
      write_reg(IRQ_ENABLE_ADDR, 8'h3F);
      set_src(1, 1'b1);
      expect_none();
      write_reg(IRQ_ENABLE_ADDR, 8'hBD);
      expect_none();
      write_reg(IRQ_ENABLE_ADDR, 8'h82);
      expect_take(16'h000B, 2'b00);
      set_src(1, 1'b0);
      end_test("enables");
      write_reg(PRIO_HIGH_ADDR, 8'h20);
      write_reg(PRIO_LOW_ADDR, 8'h20);
      write_reg(IRQ_ENABLE_ADDR, 8'hBF);
      ack_on = 1'b0;
      set_src(0, 1'b1);
      set_src(5, 1'b1);
      repeat (30) @(negedge clock);
      ack_on = 1'b1;
      expect_take(16'h002B, 2'b11);
      set_src(0, 1'b0);
      set_src(5, 1'b0);
      write_reg(PRIO_HIGH_ADDR, 8'h00);
      write_reg(PRIO_LOW_ADDR, 8'h00);
      ack_on = 1'b0;
      set_src(2, 1'b1);
      set_src(3, 1'b1);
      repeat (30) @(negedge clock);
      ack_on = 1'b1;
      expect_take(16'h0013, 2'b00);
      set_src(2, 1'b0);
      set_src(3, 1'b0);
      repeat (20) @(negedge clock);
      // A hold of zero keeps each taken level in service, so nesting can be seen.
      hold_cycles = 8'h00;
      set_src(0, 1'b1);
      expect_take(16'h0003, 2'b00);
      write_reg(PRIO_HIGH_ADDR, 8'h08);
      set_src(3, 1'b1);
      expect_take(16'h001B, 2'b10);
      set_src(2, 1'b1);
      expect_none();
      end_test("priority");
      resetn = 1'b0;
      repeat (2) @(negedge clock);
      resetn = 1'b1;
      read_reg(IRQ_ENABLE_ADDR, 8'h00);
      expect_none();
      end_test("second reset");
      complete_run();
   end
endmodule
